// [hw/aofpc_top.sv]
`timescale 1ns/1ps
// Function
// RULE_01 - offset binary gives 0x200 at zero input, 0x3FF at plus full scale and 0x000 at minus full scale.
// RULE_02 - twos complement is the offset binary code with its top bit inverted.
// RULE_03 - strap at ground or one third selects offset binary, two thirds or supply selects twos complement.
// RULE_04 - the stabilizer is on at the one third and two thirds strap levels and off at ground and supply.
// RULE_05 - the overrange flag is high beyond either full scale and the code then saturates.
// RULE_06 - output enable bar high puts all data outputs and the flag in high impedance.
// RULE_07 - the controller toggles output enable only in long idle periods, never at full speed.
// RULE_08 - shutdown low means normal conversion with driven outputs.
// RULE_09 - shutdown high with output enable bar high is sleep, with reference powered down.
// RULE_10 - after sleep the receiver treats data as invalid for milliseconds. The sink model waits SLEEP_WAIT = 400 cycles, 10 us at 40 MHz.
// RULE_11 - shutdown high with output enable bar low is nap, reference kept on, conversion stopped.
// RULE_12 - after nap the receiver discards about 100 samples of data.
// RULE_13 - in sleep and nap every digital output including the flag is high impedance.
// RULE_14 - with the stabilizer on the block samples on rising edges and needs about 100 cycles to lock.
// RULE_15 - code and flag update once per sample clock after a fixed latency and appear together.
module aofpc_top
  import aofpc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // converter core result, one per sample clock
  input wire logic [aofpc_pkg::CODE_W-1:0] core_code_i,
  input wire logic core_over_i,
  input wire logic core_under_i,
  // pins from outside
  input wire logic [1:0] mode_strap_i,
  input wire logic oe_n_i,
  input wire logic power_down_select_i,
  // parallel outputs; enable low means driven
  output logic [aofpc_pkg::CODE_W-1:0] sample_code_o,
  output logic [aofpc_pkg::CODE_W-1:0] sample_code_oe_n_o,
  output logic overrange_flag_o,
  output logic overrange_flag_oe_n_o,
  // power and stabilizer status
  output logic dcs_en_o,
  output logic dcs_locked_o,
  output logic ref_on_o,
  output logic convert_o,
  // wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o
);
  import aofpc_pkg::*;

  logic [1:0] strap_s;
  logic oe_n_s;
  logic pds_s;
  aofpc_mode_e mode_q, mode_d;
  logic [CODE_W-1:0] code_pipe_q [PIPE_LAT];
  logic [CODE_W-1:0] code_pipe_d [PIPE_LAT];
  logic [PIPE_LAT-1:0] ovr_pipe_q, ovr_pipe_d;
  logic [CODE_W-1:0] sat_code;
  logic twos_sel, dcs_sel;
  logic [6:0] lock_cnt_q, lock_cnt_d;
  logic [CODE_W-1:0] code_out_q, code_out_d;
  logic ovr_out_q, ovr_out_d;
  logic hiz;
  logic [2:0] ctrl_q, ctrl_d;
  logic [2:0] ists_q, ists_d;
  logic [2:0] ien_q, ien_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0] ev;
  logic wb_req;

  // pins are asynchronous to clk_i
  aofpc_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .d_i({mode_strap_i, oe_n_i, power_down_select_i}),
    .q_o({strap_s, oe_n_s, pds_s})
  );

  // strap decode: format and stabilizer
  always_comb begin
    twos_sel = (strap_s == STRAP_TWO_THIRD) || (strap_s == STRAP_VDD); // [RULE_03]
    dcs_sel = (strap_s == STRAP_THIRD) || (strap_s == STRAP_TWO_THIRD); // [RULE_04]
  end

  // power mode from shutdown and output enable bar
  always_comb begin
    if (!pds_s) begin
      mode_d = AOFPC_RUN; // [RULE_08]
    end else if (oe_n_s) begin
      mode_d = AOFPC_SLEEP; // [RULE_09]
    end else begin
      mode_d = AOFPC_NAP; // [RULE_11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= AOFPC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign ref_on_o = (mode_q != AOFPC_SLEEP); // [RULE_09]
  assign convert_o = (mode_q == AOFPC_RUN); // [RULE_11]

  // stabilizer lock count; restarts whenever conversion stops
  always_comb begin
    lock_cnt_d = lock_cnt_q;
    if (!dcs_sel || !convert_o) begin
      lock_cnt_d = 7'h00;
    end else if (lock_cnt_q != 7'(DCS_LOCK_CYC)) begin
      lock_cnt_d = lock_cnt_q + 7'h01; // [RULE_14]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_q <= 7'h00;
    end else begin
      lock_cnt_q <= lock_cnt_d;
    end
  end

  assign dcs_en_o = dcs_sel;
  assign dcs_locked_o = dcs_sel && (lock_cnt_q == 7'(DCS_LOCK_CYC)); // [RULE_14]

  // saturate on over or under range
  always_comb begin
    if (core_over_i) begin
      sat_code = CODE_MAX; // [RULE_05]
    end else if (core_under_i) begin
      sat_code = CODE_MIN; // [RULE_05]
    end else begin
      sat_code = core_code_i; // [RULE_01]
    end
  end

  // pipeline; code and flag move together, stalled when not converting
  always_comb begin
    code_pipe_d = code_pipe_q;
    ovr_pipe_d = ovr_pipe_q;
    if (convert_o) begin
      code_pipe_d[0] = sat_code;
      ovr_pipe_d[0] = core_over_i || core_under_i; // [RULE_05]
      for (int i = 1; i < PIPE_LAT; i++) begin
        code_pipe_d[i] = code_pipe_q[i-1]; // [RULE_15]
        ovr_pipe_d[i] = ovr_pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIPE_LAT; i++) begin
        code_pipe_q[i] <= CODE_MID;
      end
      ovr_pipe_q <= '0;
    end else begin
      code_pipe_q <= code_pipe_d;
      ovr_pipe_q <= ovr_pipe_d;
    end
  end

  // output format applied at the last stage so a strap change acts at once
  always_comb begin
    code_out_d = code_out_q;
    ovr_out_d = ovr_out_q;
    if (convert_o) begin
      code_out_d = code_pipe_q[PIPE_LAT-1] ^ {twos_sel, {(CODE_W-1){1'b0}}}; // [RULE_02]
      ovr_out_d = ovr_pipe_q[PIPE_LAT-1]; // [RULE_15]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_out_q <= CODE_MID;
      ovr_out_q <= 1'b0;
    end else begin
      code_out_q <= code_out_d;
      ovr_out_q <= ovr_out_d;
    end
  end

  // high impedance on oe bar or any power down; oe enables slow, so only for idle use
  assign hiz = oe_n_s || (mode_q != AOFPC_RUN); // [RULE_06] [RULE_13] [RULE_07]
  assign sample_code_o = code_out_q;
  assign overrange_flag_o = ovr_out_q;
  assign sample_code_oe_n_o = {CODE_W{hiz}}; // [RULE_06]
  assign overrange_flag_oe_n_o = hiz; // [RULE_13]

  // interrupt events: overrange output, sleep entry, nap entry
  assign ev[EV_OVR] = convert_o && ovr_pipe_q[PIPE_LAT-1];
  assign ev[EV_SLEEP] = (mode_d == AOFPC_SLEEP) && (mode_q != AOFPC_SLEEP);
  assign ev[EV_NAP] = (mode_d == AOFPC_NAP) && (mode_q != AOFPC_NAP);

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  // register file; set wins over clear
  always_comb begin
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    ists_d = ists_q;
    ack_d = wb_req;
    rdat_d = 32'h0000_0000;
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        REG_CTRL: ctrl_d = wb_dat_i[2:0];
        REG_IRQ_EN: ien_d = wb_dat_i[2:0];
        REG_IRQ_STAT: ists_d = ists_q & ~wb_dat_i[2:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    ists_d = ists_d | ev;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: rdat_d = {29'h0, ctrl_q};
        REG_STAT: rdat_d = {26'h0, dcs_locked_o, dcs_sel, twos_sel, hiz, mode_q};
        REG_IRQ_EN: rdat_d = {29'h0, ien_q};
        REG_IRQ_STAT: rdat_d = {29'h0, ists_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      ien_q <= IRQ_EN_RST;
      ists_q <= 3'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      ists_q <= ists_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = |(ists_q & ien_q & ~ctrl_q); // ctrl bits mask individual sources

  // assertions
  a_hiz_on_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    oe_n_s |-> overrange_flag_oe_n_o && (&sample_code_oe_n_o)) else $error("outputs driven while oe bar high"); // [RULE_06]
  a_pd_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
    pds_s |=> overrange_flag_oe_n_o) else $error("flag driven in power down"); // [RULE_13]
  a_run_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pds_s && !oe_n_s) |=> !overrange_flag_oe_n_o || oe_n_s) else $error("not driven in run"); // [RULE_08]
  a_sleep_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    (pds_s && oe_n_s) |=> !ref_on_o) else $error("reference on in sleep"); // [RULE_09]
  a_nap_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    (pds_s && !oe_n_s) |=> ref_on_o && !convert_o) else $error("nap state wrong"); // [RULE_11]
  a_twos_fmt: assert property (@(posedge clk_i) disable iff (rst_i)
    (convert_o && twos_sel) |=> sample_code_o[9] == !$past(code_pipe_q[PIPE_LAT-1][9])) else $error("msb not inverted"); // [RULE_02]
  a_dcs_map: assert property (@(posedge clk_i)
    dcs_sel == ((strap_s == STRAP_THIRD) || (strap_s == STRAP_TWO_THIRD))) else $error("stabilizer map"); // [RULE_04]
  a_ovr_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovr_out_q && !twos_sel) |-> (sample_code_o == CODE_MAX) || (sample_code_o == CODE_MIN)) else $error("no saturation"); // [RULE_05]
  a_lock_time: assert property (@(posedge clk_i) disable iff (rst_i)
    (dcs_sel && convert_o && lock_cnt_q == 7'h00) |-> !dcs_locked_o ##1 !dcs_locked_o) else $error("locked early"); // [RULE_14]
endmodule

// [hw/aofpc_pkg.sv]
package aofpc_pkg;
  // sample code width and fixed codes
  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_MID = 10'h200;
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [9:0] CODE_MIN = 10'h000;
  // pipeline latency in sample clocks
  localparam int PIPE_LAT = 5;
  // stabilizer lock time in sample clocks
  localparam int DCS_LOCK_CYC = 100;
  // strap levels, quantised to two bits
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_THIRD = 2'h1;
  localparam logic [1:0] STRAP_TWO_THIRD = 2'h2;
  localparam logic [1:0] STRAP_VDD = 2'h3;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_EN = 4'hC;
  localparam logic [3:0] REG_IRQ_CLR = 4'h0;
  localparam logic [3:0] REG_IRQ_CLR_HI = 4'h1;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  // interrupt event bit positions
  localparam int EV_OVR = 0;
  localparam int EV_SLEEP = 1;
  localparam int EV_NAP = 2;
  // power modes
  typedef enum logic [1:0] {
    AOFPC_RUN = 2'b00,
    AOFPC_NAP = 2'b01,
    AOFPC_SLEEP = 2'b10
  } aofpc_mode_e;
endpackage

// [hw/aofpc_sync.sv]
`timescale 1ns/1ps
module aofpc_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_i,
  // async level in, synced out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // two stages; first stage read only by second
  always_ff @(posedge clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
  end
  assign q_o = s2_q;
endmodule

// [testbench/aofpc_sink.sv]
`timescale 1ns/1ps
module aofpc_sink #(
  parameter int NAP_WAIT = 100,
  parameter int SLEEP_WAIT = 400
) (
  // parallel bus from the converter
  input wire logic clk_i,
  input wire logic [9:0] code_i,
  input wire logic [9:0] code_oe_n_i,
  input wire logic flag_i,
  input wire logic flag_oe_n_i,
  input wire logic ref_on_i,
  // captured word and its validity
  output logic valid_o,
  output logic [10:0] word_o
);
  int wait_q = 0;
  logic [10:0] bus_q = 11'h000;
  // a released bus is seen as the inverse of its last value each cycle, so it alternates with a stale copy
  always @(posedge clk_i) begin
    if (code_oe_n_i === 10'h000 && flag_oe_n_i === 1'b0) bus_q <= {flag_i, code_i};
    else bus_q <= ~bus_q;
  end
  assign word_o = bus_q;
  // discard window after an outage; sleep waits longer for the reference
  always @(posedge clk_i) begin
    if (ref_on_i !== 1'b1) wait_q <= SLEEP_WAIT;
    else if (code_oe_n_i !== 10'h000) wait_q <= (wait_q > NAP_WAIT) ? wait_q : NAP_WAIT;
    else if (wait_q > 0) wait_q <= wait_q - 1;
  end
  assign valid_o = (wait_q == 0);
endmodule

// [testbench/aofpc_top_test.sv]
`timescale 1ns/1ps
module aofpc_top_test;
  import aofpc_pkg::*;
  logic clk_i = 0, rst_i = 1, over = 0, under = 0, oe_n = 0, pds = 0;
  logic [9:0] code = 10'h200, oen_o, code_o;
  logic [1:0] strap = 2'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rd;
  logic we = 0, cyc = 0, stb = 0, ack, irq, flag_o, foen_o, dcs_en, lock, ref_on, conv, valid;
  logic [10:0] word;
  int n_errors = 0, samples_checked = 0;
  aofpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .core_code_i(code), .core_over_i(over),
    .core_under_i(under), .mode_strap_i(strap), .oe_n_i(oe_n), .power_down_select_i(pds),
    .sample_code_o(code_o), .sample_code_oe_n_o(oen_o), .overrange_flag_o(flag_o),
    .overrange_flag_oe_n_o(foen_o), .dcs_en_o(dcs_en), .dcs_locked_o(lock), .ref_on_o(ref_on),
    .convert_o(conv), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
  aofpc_sink sink (.clk_i(clk_i), .code_i(code_o), .code_oe_n_i(oen_o), .flag_i(flag_o),
    .flag_oe_n_i(foen_o), .ref_on_i(ref_on), .valid_o(valid), .word_o(word));
  // 40 MHz sample clock
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_errors++;
    rd = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  task automatic t_format();
    logic [9:0] tbl [3] = '{CODE_MID, CODE_MAX, CODE_MIN};
    for (int s = 0; s < 4; s++) for (int i = 0; i < 3; i++) begin
      strap <= s[1:0]; code <= tbl[i];
      settle(12);
      chk(word, {1'b0, tbl[i] ^ {s[1], 9'h000}});
      chk(dcs_en, s == 1 || s == 2);
    end
    strap <= 2'h0;
  endtask
  task automatic t_over();
    wb(1, REG_IRQ_EN, 32'h1);
    code <= 10'h155; over <= 1;
    settle(12);
    chk(word, {1'b1, CODE_MAX});
    chk(irq, 1);
    over <= 0; under <= 1; code <= 10'h0AA;
    settle(12);
    chk(word, {1'b1, CODE_MIN});
    under <= 0; code <= CODE_MID;
    settle(12);
    chk(irq, 1); // sticky until cleared
    wb(1, REG_IRQ_STAT, 32'h1);
    wb(0, REG_IRQ_STAT, 32'h0);
    chk(rd[0], 0);
    chk(irq, 0);
    wb(0, 4'h6, 32'h0);
    chk(rd, 0); // unmapped reads zero
  endtask
  task automatic t_oe();
    oe_n <= 1; // idle only, no samples wanted
    settle(5);
    chk({foen_o, oen_o}, 11'h7FF);
    oe_n <= 0;
    settle(5);
    chk({foen_o, oen_o}, 11'h000);
  endtask
  task automatic t_power();
    pds <= 1;
    settle(5);
    chk({foen_o, oen_o, ref_on, conv}, {11'h7FF, 2'b10});
    wb(0, REG_STAT, 32'h0);
    chk(rd[1:0], AOFPC_NAP);
    pds <= 0;
    settle(5);
    chk({conv, valid}, 2'b10);
    settle(110);
    chk({valid, word}, {1'b1, 1'b0, CODE_MID});
    pds <= 1; oe_n <= 1;
    settle(5);
    chk({foen_o, oen_o, ref_on}, {11'h7FF, 1'b0});
    wb(0, REG_STAT, 32'h0);
    chk(rd[1:0], AOFPC_SLEEP);
    pds <= 0; oe_n <= 0;
    settle(5);
    chk({conv, valid}, 2'b10);
    // nap entry then sleep entry both latched
    wb(0, REG_IRQ_STAT, 32'h0);
    chk(rd[2:0], 3'h6);
    // per-source mask: enable all, suppress the two power sources
    wb(1, REG_IRQ_EN, 32'h7);
    wb(1, REG_CTRL, 32'h6);
    chk(irq, 0);
    wb(1, REG_CTRL, 32'h0);
    chk(irq, 1);
    wb(1, REG_IRQ_STAT, 32'h7);
    chk(irq, 0);
  endtask
  task automatic t_lock();
    strap <= STRAP_THIRD;
    settle(5);
    chk(lock, 0);
    settle(110);
    chk(lock, 1);
  endtask
  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    settle(3);
    t_format();
    t_over();
    t_oe();
    t_power();
    t_lock();
    conclude();
  end
  // watchdog well beyond the roughly 500 cycles of tests
  initial begin
    #(25 * 5000);
    n_errors++;
    conclude();
  end
endmodule
